// ### rtl/port_e_edge_change_detect.sv
// Edge-detect change flag logic for port E pin 3, with APB register access
`timescale 1ns/1ps
module port_e_edge_change_detect (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port pin and shared flag
    input wire logic port_e_pin,
    output logic port_change_irq_flag
);
    import iocpe_pkg::*;

    logic wr_stb; // Write completes this cycle
    logic rd_stb; // Read setup cycle, data registered for the access phase
    apb_req_s req; // Decoded request
    logic level; // Synchronised pin level
    edge_s edges; // Edge pulses

    logic pin_fall_enable_ff; // Falling-edge enable, bit 3
    logic pin_rise_enable_ff; // Rising-edge enable, bit 3
    logic pin_change_flag_ff; // Recorded change for the pin
    logic irq_ff; // Shared change flag
    logic [31:0] prdata_ff; // Read data held for the access phase
    logic pslverr_ff; // Error answer for an unmapped address
    logic pready_ff; // Ready answer, high in every cycle
    logic nxt_fall_en;
    logic nxt_rise_en;
    logic nxt_flag;
    logic nxt_irq;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;
    logic nxt_pready;
    logic hit; // Enabled edge this cycle

    // 32-bit word that holds one bit at the pin position, all else zero
    function automatic logic [31:0] pin_word(input logic b);
        logic [31:0] w;
        w = RST_WORD;
        w[PIN_BIT] = b;
        return w;
    endfunction : pin_word

    // Address decode, used for the write error answer and the unmapped-address check
    function automatic logic mapped(input logic [11:0] a);
        return (a == ADDR_FALL_EN) || (a == ADDR_FLAGS) ||
               (a == ADDR_RISE_EN) || (a == ADDR_STATUS);
    endfunction : mapped

    apb_slave_if u_bus (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .req(req)
    );

    pin_sync u_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .pin_in(port_e_pin),
        .level(level),
        .edges(edges)
    );

    // Edge qualification and flag update
    always_comb begin
        hit = (edges.rise & pin_rise_enable_ff)
            | (edges.fall & pin_fall_enable_ff);
        nxt_fall_en = pin_fall_enable_ff;
        nxt_rise_en = pin_rise_enable_ff;
        nxt_flag = pin_change_flag_ff;
        nxt_irq = irq_ff;
        // Software writes use bit 3, or bit 0 for the status word; other bits are not implemented
        if (wr_stb) begin
            case (req.addr)
                ADDR_FALL_EN: nxt_fall_en = req.wdata[PIN_BIT];
                ADDR_RISE_EN: nxt_rise_en = req.wdata[PIN_BIT];
                ADDR_FLAGS: nxt_flag = req.wdata[PIN_BIT] & pin_change_flag_ff;
                ADDR_STATUS: nxt_irq = req.wdata[IRQ_BIT] & irq_ff;
                default: ;
            endcase
        end
        // Hardware set placed last so it wins a same-cycle clear
        if (hit) begin
            nxt_flag = 1'b1;
            nxt_irq = 1'b1;
        end
    end

    // Read data and error, answered in the access phase
    always_comb begin
        nxt_prdata = RST_WORD;
        nxt_pslverr = 1'b0;
        nxt_pready = 1'b1; // Zero wait states: every access phase completes at once
        if (rd_stb) begin
            case (paddr)
                ADDR_FALL_EN: nxt_prdata = pin_word(pin_fall_enable_ff);
                ADDR_RISE_EN: nxt_prdata = pin_word(pin_rise_enable_ff);
                ADDR_FLAGS: nxt_prdata = pin_word(pin_change_flag_ff);
                ADDR_STATUS: begin
                    nxt_prdata[IRQ_BIT] = irq_ff;
                    nxt_prdata[LVL_BIT] = level;
                end
                default: nxt_pslverr = 1'b1;
            endcase
        end else if (psel & ~penable & pwrite) begin
            nxt_pslverr = ~mapped(paddr);
        end
    end

    // State registers; every reset clears the enables
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_fall_enable_ff <= 1'b0;
            pin_rise_enable_ff <= 1'b0;
            pin_change_flag_ff <= 1'b0;
            irq_ff <= 1'b0;
            prdata_ff <= RST_WORD;
            pslverr_ff <= 1'b0;
            pready_ff <= 1'b1; // Ready stands through reset as well
        end else begin
            pin_fall_enable_ff <= nxt_fall_en;
            pin_rise_enable_ff <= nxt_rise_en;
            pin_change_flag_ff <= nxt_flag;
            irq_ff <= nxt_irq;
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
            pready_ff <= nxt_pready;
        end
    end

    // Outputs straight from flip-flops; pready has its own flop that never drops
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;
    assign pready = pready_ff;
    assign port_change_irq_flag = irq_ff;

    // Checks, all sampled on ref_clk and switched off while reset is held.
    // Named sequences give each step a name; only s_flags_up is shared, by three properties,
    // and each address decode is written out again in every check that leans on it.

    // An armed rising edge is at the synchroniser output this cycle
    sequence s_rise_armed;
        edges.rise && pin_rise_enable_ff;
    endsequence

    // An armed falling edge is at the synchroniser output this cycle
    sequence s_fall_armed;
        edges.fall && pin_fall_enable_ff;
    endsequence

    // A falling edge arrives unarmed while nothing else moves the flag
    sequence s_fall_ignored;
        !pin_change_flag_ff && edges.fall && !pin_fall_enable_ff && !wr_stb;
    endsequence

    // A rising edge arrives unarmed while nothing else moves the flag
    sequence s_rise_ignored;
        !pin_change_flag_ff && edges.rise && !pin_rise_enable_ff && !wr_stb;
    endsequence

    // Pin flag and shared flag both stand
    sequence s_flags_up;
        pin_change_flag_ff && irq_ff;
    endsequence

    // An edge and a flag register write land on the same clock edge
    sequence s_set_meets_write;
        hit && wr_stb && req.addr == ADDR_FLAGS;
    endsequence

    // Software writes zero to the pin flag with no edge pending
    sequence s_quiet_clear;
        wr_stb && req.addr == ADDR_FLAGS && !req.wdata[PIN_BIT] && !hit;
    endsequence

    // Software writes one to the pin flag with no edge pending
    sequence s_quiet_keep;
        wr_stb && req.addr == ADDR_FLAGS && req.wdata[PIN_BIT] && !hit;
    endsequence

    // Nothing can move the pin flag this cycle
    sequence s_flag_idle;
        !hit && !wr_stb;
    endsequence

    // Read setup of the falling enable register
    sequence s_read_fall_en;
        rd_stb && paddr == ADDR_FALL_EN;
    endsequence

    // Read setup of the pin flag register
    sequence s_read_flags;
        rd_stb && paddr == ADDR_FLAGS;
    endsequence

    // Setup cycle of any transfer to an address with no register behind it
    sequence s_unmapped_setup;
        psel && !penable && !mapped(paddr);
    endsequence

    // Armed falling edge raises both flags one cycle later
    AST_FALL_SETS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_fall_armed |=> s_flags_up)
        else $error("enabled falling edge did not set flags");

    // Armed rising edge raises both flags one cycle later
    AST_RISE_SETS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_rise_armed |=> s_flags_up)
        else $error("enabled rising edge did not set flags");

    // Falling edge with detection off leaves a clear flag clear
    AST_FALL_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_fall_ignored |=> !pin_change_flag_ff)
        else $error("disabled falling edge set flag");

    // Rising edge with detection off leaves a clear flag clear
    AST_RISE_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_rise_ignored |=> !pin_change_flag_ff)
        else $error("disabled rising edge set flag");

    // Hardware set beats a software clear in the same cycle
    AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_set_meets_write |=> s_flags_up)
        else $error("clear beat a same-cycle set");

    // Writing zero clears the recorded change
    AST_SW_CLEAR: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_quiet_clear |=> !pin_change_flag_ff)
        else $error("software clear lost");

    // Writing one never records a change by itself
    AST_SW_KEEP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_quiet_keep |=> pin_change_flag_ff == $past(pin_change_flag_ff))
        else $error("write of one moved the flag");

    // With no edge and no write the flag keeps its value
    AST_FLAG_STICKY: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_flag_idle |=> pin_change_flag_ff == $past(pin_change_flag_ff))
        else $error("flag moved without cause");

    // Only bit 3 of the two byte registers may read as one
    AST_RSVD_ZERO: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $past(rd_stb) && ($past(paddr) == ADDR_FLAGS || $past(paddr) == ADDR_FALL_EN)
        |-> (prdata & ~pin_word(1'b1)) == RST_WORD)
        else $error("unimplemented bits read non-zero");

    // Read of the falling enable returns the stored bit
    AST_RD_FALL_EN: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_read_fall_en |=> prdata_ff == pin_word($past(pin_fall_enable_ff)))
        else $error("fall enable read wrong");

    // Read of the flag register returns the recorded change
    AST_RD_FLAGS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_read_flags |=> prdata_ff == pin_word($past(pin_change_flag_ff)))
        else $error("flag read wrong");

    // A write to the falling enable stores bit 3
    AST_FALL_EN_WR: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_stb && req.addr == ADDR_FALL_EN |=> pin_fall_enable_ff == $past(pwdata[PIN_BIT]))
        else $error("fall enable write not stored");

    // The falling enable moves only on its own write
    AST_FALL_EN_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !(wr_stb && req.addr == ADDR_FALL_EN) |=> $stable(pin_fall_enable_ff))
        else $error("fall enable moved without a write");

    // Shared flag stands whenever the pin flag rises
    AST_IRQ_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(pin_change_flag_ff) |-> irq_ff)
        else $error("shared flag missing with pin flag");

    // Shared flag rises only after an armed edge
    AST_IRQ_CAUSE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(irq_ff) |-> $past(hit))
        else $error("shared flag rose without an edge");

    // Pin flag rises only after an armed edge
    AST_FLAG_CAUSE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(pin_change_flag_ff) |-> $past(hit))
        else $error("pin flag rose without an edge");

    // An unmapped address answers with an error and zero data
    AST_UNMAPPED_ERR: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_unmapped_setup |=> pslverr_ff && prdata_ff == RST_WORD)
        else $error("unmapped access not refused");

    // Outside a transfer the read data and error stay low
    AST_IDLE_QUIET: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !psel |=> !pslverr_ff && prdata_ff == RST_WORD)
        else $error("bus outputs active while idle");

endmodule : port_e_edge_change_detect

// ### rtl/iocpe_pkg.sv
// Package with register map, field positions and carrier types of the port E edge detector
package iocpe_pkg;

    // Register byte addresses on the APB bus
    localparam logic [11:0] ADDR_FALL_EN = 12'h000; // port_e_fall_edge_enable
    localparam logic [11:0] ADDR_FLAGS = 12'h004; // port_e_change_flags
    localparam logic [11:0] ADDR_RISE_EN = 12'h008; // rise enable, not in the printed map
    localparam logic [11:0] ADDR_STATUS = 12'h00C; // shared flag and live pin level

    // Field positions
    localparam int PIN_BIT = 3; // only implemented bit in each byte
    localparam int IRQ_BIT = 0; // shared change flag in the status word
    localparam int LVL_BIT = 1; // synchronised pin level in the status word

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Bus request as seen by the slave
    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
    } apb_req_s;

    // Edge events of the single pin
    typedef struct packed {
        logic rise;
        logic fall;
    } edge_s;

endpackage : iocpe_pkg

// ### rtl/pin_sync.sv
// Two-stage synchroniser and edge detector for the port pin
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Pin in, level and edges out
    input wire logic pin_in,
    output logic level,
    output iocpe_pkg::edge_s edges
);
    import iocpe_pkg::*;

    logic meta_ff; // First stage, read only by the second stage
    logic sync_ff; // Second stage
    logic prev_ff; // Previous synchronised sample
    logic nxt_meta;
    logic nxt_sync;
    logic nxt_prev;

    // Next values of the sampling chain
    always_comb begin
        nxt_meta = pin_in;
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
    end

    // Register the chain; reset assumes the pin low, so a high pin at release reads as a rise
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    // Compare current and previous samples
    assign level = sync_ff;
    assign edges.rise = sync_ff & ~prev_ff;
    assign edges.fall = ~sync_ff & prev_ff;

endmodule : pin_sync

// ### rtl/apb_slave_if.sv
// APB slave front end: decodes a write access phase or a read setup cycle into a one-cycle strobe
`timescale 1ns/1ps
module apb_slave_if (
    // APB side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // Decoded request
    output logic wr_stb,
    output logic rd_stb,
    output iocpe_pkg::apb_req_s req
);
    import iocpe_pkg::*;

    // Access phase completes in its first cycle, pready is always high
    always_comb begin
        wr_stb = psel & penable & pwrite;
        rd_stb = psel & ~penable & ~pwrite;
        req.addr = paddr;
        req.write = pwrite;
        req.wdata = pwdata;
    end

endmodule : apb_slave_if

// ### tb/pin_driver.sv
// Partner model: external logic source that drives the port pin
`timescale 1ns/1ps
module pin_driver (
    // Clock
    input wire logic ref_clk,
    // Requested level and the pin it drives
    input wire logic want,
    output logic pin
);
    // Starts low so the synchroniser sees no edge at release of reset
    initial pin = 1'b0;

    // Moves just after an edge, as a synchronous source would; holds level between changes
    always @(posedge ref_clk) begin
        pin <= want;
    end
endmodule : pin_driver

// ### tb/port_e_edge_change_detect_tb.sv
// Self-checking testbench of the port E edge change detector
`timescale 1ns/1ps
module port_e_edge_change_detect_tb;
    import iocpe_pkg::*;

    logic ref_clk = 1'b0; // 25 MHz system clock
    logic arst_n = 1'b0; // Active low reset
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic want = 1'b0; // Level asked of the partner
    logic port_e_pin;
    logic port_change_irq_flag;
    int err_count = 0;
    int tests_run = 0;
    logic [31:0] rd_data; // Last read word
    logic rd_err; // Last error response

    // Half period of 20 ns
    always #20 ref_clk = ~ref_clk;

    port_e_edge_change_detect i_dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_e_pin(port_e_pin),
        .port_change_irq_flag(port_change_irq_flag)
    );

    pin_driver i_pin (.ref_clk(ref_clk), .want(want), .pin(port_e_pin));

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; entered just after an edge, leaves one idle cycle behind it
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Wait for the slave answer; only the watchdog ends a hang
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    // Read a register and compare it
    task automatic rd(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        check(rd_data, exp);
        check(32'(rd_err), 32'h0000_0000);
    endtask : rd

    // Pin change plus margin for the two synchroniser flops and the flag register
    task automatic pin_set(input logic v);
        want <= v;
        repeat (8) @(posedge ref_clk);
    endtask : pin_set

    // Counts, verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // Watchdog well beyond the roughly 150 cycles the tests need
    initial begin
        repeat (4000) @(posedge ref_clk);
        err_count++;
        complete_run();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        check(32'(pready), 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            rd(12'(4 * i), RST_WORD);
        end
        $display("test reset values done");
        // Only bit 3 may stick; writing ones to flags records nothing
        apb(1'b1, ADDR_FALL_EN, 32'hFFFF_FFFF);
        rd(ADDR_FALL_EN, 32'h0000_0008);
        apb(1'b1, ADDR_RISE_EN, 32'hFFFF_FFFF);
        rd(ADDR_RISE_EN, 32'h0000_0008);
        apb(1'b1, ADDR_FLAGS, 32'hFFFF_FFFF);
        rd(ADDR_FLAGS, 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0000_0000);
        check(rd_data, 32'h0000_0000);
        check(32'(rd_err), 32'h0000_0001);
        // A write to a hole is refused and leaves the registers alone
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        check(32'(rd_err), 32'h0000_0001);
        rd(ADDR_FALL_EN, 32'h0000_0008);
        $display("test register access done");
        // Rising edge with rise enable only
        apb(1'b1, ADDR_FALL_EN, 32'h0000_0000);
        pin_set(1'b1);
        rd(ADDR_FLAGS, 32'h0000_0008);
        check(32'(port_change_irq_flag), 32'h0000_0001);
        rd(ADDR_STATUS, 32'h0000_0003);
        apb(1'b1, ADDR_FLAGS, 32'h0000_0000);
        apb(1'b1, ADDR_STATUS, 32'h0000_0000);
        rd(ADDR_FLAGS, 32'h0000_0000);
        rd(ADDR_STATUS, 32'h0000_0002);
        // Falling edge while falling detection is off
        pin_set(1'b0);
        rd(ADDR_FLAGS, 32'h0000_0000);
        check(32'(port_change_irq_flag), 32'h0000_0000);
        $display("test rising edge done");
        // Falling detection armed, rising disarmed
        apb(1'b1, ADDR_FALL_EN, 32'h0000_0008);
        apb(1'b1, ADDR_RISE_EN, 32'h0000_0000);
        pin_set(1'b1);
        rd(ADDR_FLAGS, 32'h0000_0000);
        pin_set(1'b0);
        rd(ADDR_FLAGS, 32'h0000_0008);
        check(32'(port_change_irq_flag), 32'h0000_0001);
        $display("test falling edge done");
        // Edge and software clear meet on one clock edge; the set must win
        apb(1'b1, ADDR_FLAGS, 32'h0000_0000);
        pin_set(1'b1);
        rd(ADDR_FLAGS, 32'h0000_0000);
        // Pin moves one edge after want, then two sync stages: event lands with the write
        want <= 1'b0;
        repeat (2) @(posedge ref_clk);
        apb(1'b1, ADDR_FLAGS, 32'h0000_0000);
        repeat (4) @(posedge ref_clk);
        rd(ADDR_FLAGS, 32'h0000_0008);
        check(32'(port_change_irq_flag), 32'h0000_0001);
        $display("test set beats clear done");
        // Reset in mid-run clears enables and flags
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        rd(ADDR_FALL_EN, 32'h0000_0000);
        rd(ADDR_FLAGS, 32'h0000_0000);
        rd(ADDR_STATUS, 32'h0000_0000);
        check(32'(port_change_irq_flag), 32'h0000_0000);
        $display("test second reset done");
        complete_run();
    end
endmodule : port_e_edge_change_detect_tb
